// File: ieh_cfg.svh
// Constants of the interprocessor event handshake block: sizes, offsets, reset values.
// Assumes inclusion by bare name from the package and the design modules.
// Functional notes
// - Each direction has 32 channels, and bit n of its set, flag and acknowledge registers is channel n.
// - Channels 0 to 3 of each direction also drive an interrupt so software may skip polling.
// - Writing one to a bit of a direction's set register sets the matching flag bit.
// - Writing one to a bit of the acknowledge register clears the matching flag bit.
// - There are two independent directions, each with its own set, flag and acknowledge registers.
// - The control-to-master direction works exactly like the master-to-control one with roles swapped.
// - The sender's flag view and the receiver's status view are one physical register.
`ifndef IEH_CFG_SVH
`define IEH_CFG_SVH

`define IEH_CHANNELS 32
`define IEH_IRQ_CHANNELS 4
`define IEH_DATA_W 32
`define IEH_SEL_W 4
`define IEH_ADR_W 6
`define IEH_INT_W 8
`define IEH_PORTS 2

`define IEH_OFF_TX_SET 6'h00
`define IEH_OFF_TX_FLAG 6'h04
`define IEH_OFF_RX_STATUS 6'h08
`define IEH_OFF_RX_ACK 6'h0C
`define IEH_OFF_INT_STATUS 6'h10
`define IEH_OFF_INT_MASK 6'h14

`define IEH_FLAG_RESET 32'h0000_0000
`define IEH_DATA_ZERO 32'h0000_0000
`define IEH_INT_RESET 8'h00
`define IEH_CHIRQ_RESET 4'h0

`endif

// File: ieh_pkg.sv
// Types shared by the interprocessor event handshake modules.
// Assumes ieh_cfg.svh is reachable on the include path.
`include "ieh_cfg.svh"

package ieh_pkg;

    // One classic Wishbone request as driven by a processor.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [`IEH_ADR_W-1:0] adr;
        logic [`IEH_SEL_W-1:0] sel;
        logic [`IEH_DATA_W-1:0] dat;
    } ieh_wb_req_t;

    // The slave's answer to one request.
    typedef struct packed {
        logic ack;
        logic [`IEH_DATA_W-1:0] dat;
    } ieh_wb_rsp_t;

endpackage : ieh_pkg

// File: ieh_direction.sv
// One handshake direction: the single physical flag register of its channels.
// Assumes set and acknowledge masks are single-cycle pulses on sys_clk.
`include "ieh_cfg.svh"

module ieh_direction #(
    parameter int CHANNELS = `IEH_CHANNELS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [CHANNELS-1:0] setMask,
    input wire logic [CHANNELS-1:0] ackMask,
    output logic [CHANNELS-1:0] flag_r
);

    logic [CHANNELS-1:0] flag_nxt;

    // A set arriving in the same cycle as its acknowledge wins, so no event is lost.
    always_comb begin
        flag_nxt = (flag_r & ~ackMask) | setMask;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= CHANNELS'(`IEH_FLAG_RESET);
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule : ieh_direction

// File: ieh_top.sv
// Top of the interprocessor event handshake block with one Wishbone slave per processor.
// Assumes both processors share sys_clk and reset_n; port A is the master subsystem,
// port B the control subsystem.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`include "ieh_cfg.svh"

module ieh_top #(
    parameter int CHANNELS = `IEH_CHANNELS,
    parameter int IRQ_CHANNELS = `IEH_IRQ_CHANNELS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input ieh_pkg::ieh_wb_req_t wbReqA,
    output ieh_pkg::ieh_wb_rsp_t wbRspA,
    input ieh_pkg::ieh_wb_req_t wbReqB,
    output ieh_pkg::ieh_wb_rsp_t wbRspB,
    output logic [IRQ_CHANNELS-1:0] chanIrqA,
    output logic [IRQ_CHANNELS-1:0] chanIrqB,
    output logic irqA,
    output logic irqB
);

    localparam int PORTS = `IEH_PORTS;
    localparam int LANES = `IEH_SEL_W;

    // Index 0 is port A, index 1 is port B.
    // Direction d is sent by port d and received by the other port.
    ieh_pkg::ieh_wb_req_t req [PORTS];
    ieh_pkg::ieh_wb_rsp_t rsp_r [PORTS];
    ieh_pkg::ieh_wb_rsp_t rsp_nxt [PORTS];

    logic [CHANNELS-1:0] flag [PORTS];
    logic [CHANNELS-1:0] flagPrev_r [PORTS];
    logic [CHANNELS-1:0] flagPrev_nxt [PORTS];
    logic [CHANNELS-1:0] setMask [PORTS];
    logic [CHANNELS-1:0] ackMask [PORTS];
    logic [`IEH_DATA_W-1:0] laneMask [PORTS];

    logic [`IEH_INT_W-1:0] intStatus_r [PORTS];
    logic [`IEH_INT_W-1:0] intStatus_nxt [PORTS];
    logic [`IEH_INT_W-1:0] intMask_r [PORTS];
    logic [`IEH_INT_W-1:0] intMask_nxt [PORTS];
    logic [IRQ_CHANNELS-1:0] chanIrq_r [PORTS];
    logic [IRQ_CHANNELS-1:0] chanIrq_nxt [PORTS];
    logic irq_r [PORTS];
    logic irq_nxt [PORTS];

    assign req[0] = wbReqA;
    assign req[1] = wbReqB;
    assign wbRspA = rsp_r[0];
    assign wbRspB = rsp_r[1];
    assign chanIrqA = chanIrq_r[0];
    assign chanIrqB = chanIrq_r[1];
    assign irqA = irq_r[0];
    assign irqB = irq_r[1];

    // Two independent directions, each its own flag register.
    for (genvar d = 0; d < PORTS; d++) begin : g_dir
        ieh_direction #(
            .CHANNELS(CHANNELS)
        ) u_direction (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .setMask(setMask[d]),
            .ackMask(ackMask[d]),
            .flag_r(flag[d])
        );

        // Previous flag value, used to find channels that became set or free.
        always_comb begin
            flagPrev_nxt[d] = flag[d];
        end

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                flagPrev_r[d] <= CHANNELS'(`IEH_FLAG_RESET);
            end else begin
                flagPrev_r[d] <= flagPrev_nxt[d];
            end
        end
    end

    // Byte lane enables widened to one mask bit per data bit.
    for (genvar p = 0; p < PORTS; p++) begin : g_lane
        for (genvar b = 0; b < LANES; b++) begin : g_byte
            assign laneMask[p][b*8 +: 8] = {8{req[p].sel[b]}};
        end
    end

    // Acknowledge writes of a direction come from its receiving port.
    always_comb begin
        for (int d = 0; d < PORTS; d++) begin
            setMask[d] = CHANNELS'(`IEH_FLAG_RESET);
            ackMask[d] = CHANNELS'(`IEH_FLAG_RESET);
        end
        for (int p = 0; p < PORTS; p++) begin
            if (req[p].cyc && req[p].stb && rsp_r[p].ack && req[p].we) begin
                if (req[p].adr == `IEH_OFF_TX_SET) begin
                    setMask[p] = CHANNELS'(req[p].dat & laneMask[p]);
                end
                if (req[p].adr == `IEH_OFF_RX_ACK) begin
                    ackMask[PORTS-1-p] = CHANNELS'(req[p].dat & laneMask[p]);
                end
            end
        end
    end

    // Per-port bus slave, interrupt status, mask and channel interrupts.
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        localparam int RX = PORTS - 1 - p;

        logic access;
        logic commit;
        logic [IRQ_CHANNELS-1:0] rxArrive;
        logic [IRQ_CHANNELS-1:0] txFree;

        assign access = req[p].cyc && req[p].stb;
        assign commit = access && rsp_r[p].ack;

        // Receive events: a channel flag rose; send events: a channel flag fell.
        assign rxArrive = flag[RX][IRQ_CHANNELS-1:0] & ~flagPrev_r[RX][IRQ_CHANNELS-1:0];
        assign txFree = ~flag[p][IRQ_CHANNELS-1:0] & flagPrev_r[p][IRQ_CHANNELS-1:0];

        always_comb begin
            rsp_nxt[p].ack = access && !rsp_r[p].ack;
            rsp_nxt[p].dat = `IEH_DATA_ZERO;
            if (access && !rsp_r[p].ack && !req[p].we) begin
                unique case (req[p].adr)
                    `IEH_OFF_TX_FLAG: begin
                        rsp_nxt[p].dat = `IEH_DATA_W'(flag[p]);
                    end
                    `IEH_OFF_RX_STATUS: begin
                        rsp_nxt[p].dat = `IEH_DATA_W'(flag[RX]);
                    end
                    `IEH_OFF_INT_STATUS: begin
                        rsp_nxt[p].dat = `IEH_DATA_W'(intStatus_r[p]);
                    end
                    `IEH_OFF_INT_MASK: begin
                        rsp_nxt[p].dat = `IEH_DATA_W'(intMask_r[p]);
                    end
                    default: begin
                        // Set, acknowledge and unmapped offsets read as zero.
                        rsp_nxt[p].dat = `IEH_DATA_ZERO;
                    end
                endcase
            end
        end

        always_comb begin
            intStatus_nxt[p] = intStatus_r[p];
            intMask_nxt[p] = intMask_r[p];
            // A read clears only the bits it returned; new events still land.
            if (commit && !req[p].we && req[p].adr == `IEH_OFF_INT_STATUS) begin
                intStatus_nxt[p] = intStatus_r[p] & ~rsp_r[p].dat[`IEH_INT_W-1:0];
            end
            intStatus_nxt[p] = intStatus_nxt[p] | `IEH_INT_W'({txFree, rxArrive});
            if (commit && req[p].we && req[p].adr == `IEH_OFF_INT_MASK && req[p].sel[0]) begin
                intMask_nxt[p] = req[p].dat[`IEH_INT_W-1:0];
            end
            // The channel interrupt follows the received flag itself.
            chanIrq_nxt[p] = flag[RX][IRQ_CHANNELS-1:0];
            irq_nxt[p] = |(intStatus_r[p] & intMask_r[p]);
        end

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                rsp_r[p].ack <= 1'b0;
                rsp_r[p].dat <= `IEH_DATA_ZERO;
                intStatus_r[p] <= `IEH_INT_RESET;
                intMask_r[p] <= `IEH_INT_RESET;
                chanIrq_r[p] <= IRQ_CHANNELS'(`IEH_CHIRQ_RESET);
                irq_r[p] <= 1'b0;
            end else begin
                rsp_r[p] <= rsp_nxt[p];
                intStatus_r[p] <= intStatus_nxt[p];
                intMask_r[p] <= intMask_nxt[p];
                chanIrq_r[p] <= chanIrq_nxt[p];
                irq_r[p] <= irq_nxt[p];
            end
        end
    end

endmodule : ieh_top

// File: ieh_top_monitor.sv
// Port checker of the handshake block, bound into ieh_top.
// Assumes one clock domain and the per-port offsets of ieh_cfg.svh.
`include "ieh_cfg.svh"

module ieh_top_monitor #(
    parameter int CHANNELS = 32,
    parameter int IRQ_CHANNELS = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input ieh_pkg::ieh_wb_req_t wbReqA,
    input ieh_pkg::ieh_wb_rsp_t wbRspA,
    input ieh_pkg::ieh_wb_req_t wbReqB,
    input ieh_pkg::ieh_wb_rsp_t wbRspB,
    input wire logic [IRQ_CHANNELS-1:0] chanIrqA,
    input wire logic [IRQ_CHANNELS-1:0] chanIrqB,
    input wire logic irqA,
    input wire logic irqB
);
    function automatic logic [3:0] wr_low(ieh_pkg::ieh_wb_req_t q, logic a, logic [5:0] off);
        return (a && q.cyc && q.stb && q.we && q.adr == off && q.sel[0]) ? q.dat[3:0] : 4'h0;
    endfunction : wr_low
    function automatic logic rd_hit(ieh_pkg::ieh_wb_req_t q, logic a, logic [5:0] off);
        return a && q.cyc && q.stb && !q.we && q.adr == off;
    endfunction : rd_hit
    logic [3:0] setA, setB, ackA, ackB;
    assign setA = wr_low(wbReqA, wbRspA.ack, `IEH_OFF_TX_SET);
    assign setB = wr_low(wbReqB, wbRspB.ack, `IEH_OFF_TX_SET);
    assign ackA = wr_low(wbReqA, wbRspA.ack, `IEH_OFF_RX_ACK);
    assign ackB = wr_low(wbReqB, wbRspB.ack, `IEH_OFF_RX_ACK);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_pulse(logic a);
        a ##1 !a;
    endsequence
    property p_ackA; wbReqA.cyc && wbReqA.stb && !wbRspA.ack |=> s_pulse(wbRspA.ack); endproperty
    property p_ackB; wbReqB.cyc && wbReqB.stb && !wbRspB.ack |=> s_pulse(wbRspB.ack); endproperty
    property p_setM2c; setA != 4'h0 |=> ##1 (chanIrqB[3:0] & $past(setA, 2)) == $past(setA, 2);
    endproperty
    property p_setC2m; setB != 4'h0 |=> ##1 (chanIrqA[3:0] & $past(setB, 2)) == $past(setB, 2);
    endproperty
    property p_clrM2c; ackB != 4'h0 && setA == 4'h0 |=> ##1 (chanIrqB[3:0] & $past(ackB, 2)) == 4'h0;
    endproperty
    property p_clrC2m; ackA != 4'h0 && setB == 4'h0 |=> ##1 (chanIrqA[3:0] & $past(ackA, 2)) == 4'h0;
    endproperty
    property p_viewA; rd_hit(wbReqA, wbRspA.ack, `IEH_OFF_TX_FLAG) |-> wbRspA.dat[3:0] == chanIrqB[3:0];
    endproperty
    property p_viewB; rd_hit(wbReqB, wbRspB.ack, `IEH_OFF_RX_STATUS) |-> wbRspB.dat[3:0] == chanIrqB[3:0];
    endproperty
    a_ackA: assert property (p_ackA)
        else $error("port A ack is not a single pulse one cycle after the request");
    a_ackB: assert property (p_ackB)
        else $error("port B ack is not a single pulse one cycle after the request");
    a_setM2c: assert property (p_setM2c)
        else $error("master to control set did not raise the channel interrupt");
    a_setC2m: assert property (p_setC2m)
        else $error("control to master set did not raise the channel interrupt");
    a_clrM2c: assert property (p_clrM2c)
        else $error("master to control ack did not clear the channel interrupt");
    a_clrC2m: assert property (p_clrC2m)
        else $error("control to master ack did not clear the channel interrupt");
    a_viewA: assert property (p_viewA)
        else $error("sender flag view differs from the flag register");
    a_viewB: assert property (p_viewB)
        else $error("receiver status view differs from the flag register");
endmodule : ieh_top_monitor

bind ieh_top ieh_top_monitor #(.CHANNELS(CHANNELS), .IRQ_CHANNELS(IRQ_CHANNELS)) u_mon (
    .sys_clk(sys_clk), .reset_n(reset_n), .wbReqA(wbReqA), .wbRspA(wbRspA),
    .wbReqB(wbReqB), .wbRspB(wbRspB), .chanIrqA(chanIrqA), .chanIrqB(chanIrqB),
    .irqA(irqA), .irqB(irqB));

// File: ieh_cpu_model.sv
// Processor model: a classic Wishbone master issuing single cycles on request.
// Assumes the bench bounds every wait for ack with its own cycle counter.
module ieh_cpu_model (
    input wire logic sys_clk,
    output ieh_pkg::ieh_wb_req_t req,
    input ieh_pkg::ieh_wb_rsp_t rsp
);
    initial req = '0;
    task automatic xfer(input logic we, input logic [5:0] adr, input logic [3:0] sel,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: wd};
        do @(posedge sys_clk); while (rsp.ack !== 1'b1);
        rd = rsp.dat;
        // Released lines show the inverse of their last value, never a stale copy.
        req <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: ~sel, dat: ~wd};
    endtask : xfer
endmodule : ieh_cpu_model

// File: ieh_top_tb.sv
// Self-checking bench of the handshake block with one processor model per port.
// Assumes the per-port offsets of ieh_cfg.svh.
`include "ieh_cfg.svh"

module ieh_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset_n, irqA, irqB;
    ieh_pkg::ieh_wb_req_t wbReqA, wbReqB;
    ieh_pkg::ieh_wb_rsp_t wbRspA, wbRspB;
    logic [3:0] chanIrqA, chanIrqB;
    logic [31:0] rdat;
    int error_cnt = 0, num_checks = 0, cycleCnt = 0;
    ieh_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .wbReqA(wbReqA), .wbRspA(wbRspA),
        .wbReqB(wbReqB), .wbRspB(wbRspB), .chanIrqA(chanIrqA), .chanIrqB(chanIrqB),
        .irqA(irqA), .irqB(irqB));
    ieh_cpu_model u_cpuA (.sys_clk(sys_clk), .req(wbReqA), .rsp(wbRspA));
    ieh_cpu_model u_cpuB (.sys_clk(sys_clk), .req(wbReqB), .rsp(wbRspB));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == 2000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input bit p, input logic we, input logic [5:0] adr, input logic [3:0] sel,
                       input logic [31:0] wd);
        if (p)
            u_cpuB.xfer(we, adr, sel, wd, rdat);
        else
            u_cpuA.xfer(we, adr, sel, wd, rdat);
    endtask : bus
    task automatic rd(input bit p, input logic [5:0] adr, input string what, input logic [31:0] e);
        bus(p, 1'b0, adr, 4'hF, 32'h0000_0000);
        chk(what, e, rdat);
    endtask : rd
    // Sender p raises channels 0 and 31, the receiver clears them one at a time, channel 31 through lane 3 alone.
    // No message memory sits in this block, so each transfer here is a bare event.
    task automatic t_handshake(input bit p);
        rd(p, `IEH_OFF_TX_FLAG, "sender flag idle", 32'h0000_0000);
        bus(p, 1'b1, `IEH_OFF_TX_SET, 4'hF, 32'h8000_0001);
        rd(!p, `IEH_OFF_RX_STATUS, "receiver status", 32'h8000_0001);
        rd(p, `IEH_OFF_TX_FLAG, "sender flag view", 32'h8000_0001);
        rd(p, `IEH_OFF_RX_STATUS, "other direction", 32'h0000_0000);
        rd(p, `IEH_OFF_TX_SET, "set readback", 32'h0000_0000);
        chk("receiver chanIrq set", 32'h0000_0001, p ? chanIrqA : chanIrqB);
        bus(p, 1'b1, `IEH_OFF_TX_SET, 4'h1, 32'hFFFF_FF00);
        bus(!p, 1'b1, `IEH_OFF_RX_ACK, 4'hF, 32'h0000_0001);
        rd(!p, `IEH_OFF_RX_STATUS, "after first ack", 32'h8000_0000);
        chk("receiver chanIrq freed", 32'h0000_0000, p ? chanIrqA : chanIrqB);
        bus(!p, 1'b1, `IEH_OFF_RX_ACK, 4'h8, 32'hFFFF_FFFF);
        rd(p, `IEH_OFF_TX_FLAG, "flag freed", 32'h0000_0000);
        bus(p, 1'b1, `IEH_OFF_TX_SET, 4'h2, 32'hFFFF_FFFF);
        rd(!p, `IEH_OFF_RX_STATUS, "lane one set", 32'h0000_FF00);
        rd(!p, `IEH_OFF_RX_ACK, "ack readback", 32'h0000_0000);
        // The direction is left idle so that the other direction's run starts clean.
        bus(!p, 1'b1, `IEH_OFF_RX_ACK, 4'h2, 32'h0000_FF00);
        rd(p, `IEH_OFF_TX_FLAG, "lane one freed", 32'h0000_0000);
    endtask : t_handshake
    // Channel 3 raises port B's interrupt; its release is seen at port A, masked and then not.
    task automatic t_irq();
        bus(1'b1, 1'b1, `IEH_OFF_INT_MASK, 4'h1, 32'h0000_00FF);
        rd(1'b1, `IEH_OFF_INT_MASK, "mask readback", 32'h0000_00FF);
        bus(1'b0, 1'b1, `IEH_OFF_TX_SET, 4'h1, 32'h0000_0008);
        repeat (3) @(posedge sys_clk);
        chk("irqB raised", 32'h0000_0001, irqB);
        rd(1'b1, `IEH_OFF_INT_STATUS, "status B", 32'h0000_0008);
        rd(1'b1, `IEH_OFF_INT_STATUS, "status B cleared", 32'h0000_0000);
        chk("irqB cleared", 32'h0000_0000, irqB);
        bus(1'b1, 1'b1, `IEH_OFF_RX_ACK, 4'h1, 32'h0000_0008);
        repeat (3) @(posedge sys_clk);
        chk("irqA masked", 32'h0000_0000, irqA);
        bus(1'b0, 1'b1, `IEH_OFF_INT_MASK, 4'h1, 32'h0000_0080);
        repeat (2) @(posedge sys_clk);
        chk("irqA raised", 32'h0000_0001, irqA);
        rd(1'b0, `IEH_OFF_INT_STATUS, "status A freed", 32'h0000_0080);
        repeat (2) @(posedge sys_clk);
        chk("irqA cleared", 32'h0000_0000, irqA);
        rd(1'b0, 6'h18, "unmapped read", 32'h0000_0000);
    endtask : t_irq
    initial begin
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_irq();
        t_handshake(1'b0);
        t_handshake(1'b1);
        end_of_test();
    end
endmodule : ieh_top_tb
